// ==== logic/tscw_pkg.sv ====
// constants for the terminal status control word decoder
// assumes one 20 MHz clock and a fetched 16-bit control word strobe
package tscw_pkg;
    localparam int          CLK_HZ          = 20_000_000;
    localparam int          WORD_W          = 16;
    localparam int          BIT_DISP        = 15;
    localparam int          BIT_PRIO        = 14;
    localparam int          BIT_BUZ_CONT    = 13;
    localparam int          BIT_BUZ_INT     = 12;
    localparam int          BIT_BL_FLASH    = 8;
    localparam int          HALF_SEC_MS     = 500;
    localparam int          HALF_SEC_CYC    = CLK_HZ / 1000 * HALF_SEC_MS;
    localparam int          IDLE_DEF_S      = 600;
    localparam logic [15:0] DEFINED_MASK    = 16'hF100;
    localparam logic [1:0]  BUZ_OFF         = 2'h0;
    localparam logic [1:0]  BUZ_CONT        = 2'h1;
    localparam logic [1:0]  BUZ_INT         = 2'h2;
    typedef enum logic [2:0] {
        TSCW_ST_WAIT  = 3'b001,
        TSCW_ST_SHOW  = 3'b010,
        TSCW_ST_BLANK = 3'b100
    } tscw_state_e;
endpackage

// ==== logic/tscw_top.sv ====
// terminal status control word decoder
// assumes word fetch strobe and touch/attribute pulses synchronous to i_clk
`timescale 1ns/1ps
module tscw_top #(
    parameter int HALF_CYC = tscw_pkg::HALF_SEC_CYC,
    parameter longint IDLE_CYC = longint'(tscw_pkg::IDLE_DEF_S) * tscw_pkg::CLK_HZ
) (
    // clock and reset
    input  wire logic                         i_clk,
    input  wire logic                         i_rst,
    // control word fetch
    input  wire logic                         i_fetch,
    input  wire logic [tscw_pkg::WORD_W-1:0]  i_word,
    // operator side
    input  wire logic                         i_touch,
    input  wire logic                         i_touch_buz_stop,
    input  wire logic                         i_buz_msw_en,
    input  wire logic                         i_idle_en,
    // screen attributes
    input  wire logic                         i_scr_shown,
    input  wire logic [1:0]                   i_scr_buz_attr,
    input  wire logic                         i_scr_bl_flash,
    input  wire logic                         i_timeout_blank,
    // link priority
    input  wire logic                         i_other_prio_reg,
    // outputs
    output logic                              o_screen_on,
    output logic                              o_backlight,
    output logic                              o_buzzer,
    output logic                              o_priority,
    output logic [tscw_pkg::WORD_W-1:0]       o_change
);
    import tscw_pkg::*;

    // behaviour in short:
    // - the word is acted on only at fetches; nothing happens from reset
    //   until the first one, which treats every defined bit as changed
    // - later fetches act on defined bits that differ from the last fetch,
    //   so a host that wants an action again must move the bit again
    // - the fetched word is only ever read, never written back, so it may
    //   disagree with what screen attributes or switches have since done
    // - touch and buzzer-stop switches override a fetch in the same cycle
    // - a later priority registration by another terminal drops ours
    // - with the display bit low, the flash bit is remembered but the
    //   backlight stays dark, so flashing resumes when the screen returns
    // - buzzer-stop silences whatever kind is sounding, until the next
    //   change of a buzzer bit or a screen attribute asks for sound again
    // - the half-second phase runs free; the first tone or flash period
    //   after a request may therefore be shorter than half a second
    // - the idle limit runs to minutes at full clock, hence the wide counter

    ////////////////////////////////////////////////////////////////////////
    // local widths and counter limits
    ////////////////////////////////////////////////////////////////////////

    localparam int                CNT_W    = 32;
    localparam int                IDLE_W   = 40;
    localparam logic [CNT_W-1:0]  CNT_ONE  = CNT_W'(1);
    localparam logic [IDLE_W-1:0] IDLE_ONE = IDLE_W'(1);
    localparam logic [CNT_W-1:0]  HALF_LIM = CNT_W'(HALF_CYC - 1);
    localparam logic [IDLE_W-1:0] IDLE_LIM = IDLE_W'(IDLE_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // registered state, one packed record
    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        // display state machine and last fetched word
        tscw_state_e        st;
        logic [WORD_W-1:0]  prev;
        logic [WORD_W-1:0]  chg;
        // link priority and buzzer kind
        logic               prio;
        logic [1:0]         buz;
        // backlight flashing and screen blanking
        logic               bl_flash;
        logic               scr_off;
        // half-second phase timer
        logic [CNT_W-1:0]   half_cnt;
        logic               phase;
        // inactivity timer
        logic [IDLE_W-1:0]  idle_cnt;
        logic               idle_off;
    } tscw_s;

    // waiting for the first fetch, everything else cleared
    localparam tscw_s S_RESET = '{st: TSCW_ST_WAIT, default: '0};

    tscw_s             s_reg;
    tscw_s             s_next;

    // per-bit change detection on a fetch
    wire  [WORD_W-1:0] edge_rise;
    wire  [WORD_W-1:0] edge_fall;
    logic              first_fetch;

    // actions requested by the fetched word
    logic              disp_off_req;
    logic              disp_on_req;
    logic              prio_set_req;
    logic              prio_clr_req;
    logic              buz_upd_req;
    logic              flash_upd_req;

    // timer end flags
    logic              half_done;
    logic              idle_done;

    // output helpers
    logic              scr_lit;
    logic              flash_dark;
    logic              tone_on;

    ////////////////////////////////////////////////////////////////////////
    // decoding helpers
    ////////////////////////////////////////////////////////////////////////

    // buzzer kind requested by the two control bits
    function automatic logic [1:0] buz_from_bits(
        input logic cont,
        input logic intm
    );
        logic [1:0] sel;
        sel = BUZ_OFF;
        if (cont) begin
            sel = BUZ_CONT;
        end else if (intm) begin
            sel = BUZ_INT;
        end
        return sel;
    endfunction

    // whether a buzzer kind sounds in the current half-second phase
    function automatic logic buz_sounding(
        input logic [1:0] sel,
        input logic       ph
    );
        logic on;
        on = 1'b0;
        if (sel == BUZ_CONT) begin
            on = 1'b1;
        end else if (sel == BUZ_INT) begin
            on = !ph;
        end
        return on;
    endfunction

    // end test shared by the phase and idle timers
    function automatic logic reached(
        input logic [IDLE_W-1:0] cnt,
        input logic [IDLE_W-1:0] lim
    );
        return cnt >= lim;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // change detection, one slice per word bit
    ////////////////////////////////////////////////////////////////////////

    // before the first fetch every defined bit counts as changed
    assign first_fetch = (s_reg.st == TSCW_ST_WAIT);

    // undefined bits never flag a change; a bit that stays put does nothing
    // whatever value it holds
    for (genvar b = 0; b < WORD_W; b++) begin : g_edge
        logic now_bit;
        logic old_bit;
        logic watch;

        assign now_bit      = i_word[b];
        assign old_bit      = first_fetch ? ~i_word[b] : s_reg.prev[b];
        assign watch        = i_fetch && DEFINED_MASK[b];
        assign edge_rise[b] = watch && now_bit && !old_bit;
        assign edge_fall[b] = watch && !now_bit && old_bit;
    end

    ////////////////////////////////////////////////////////////////////////
    // actions requested by the word
    ////////////////////////////////////////////////////////////////////////

    // display bit low blanks, high restores
    assign disp_off_req  = edge_fall[BIT_DISP];
    assign disp_on_req   = edge_rise[BIT_DISP];

    // priority bit registers or cancels
    assign prio_set_req  = edge_rise[BIT_PRIO];
    assign prio_clr_req  = edge_fall[BIT_PRIO];

    // either buzzer bit moving re-decodes the buzzer kind
    assign buz_upd_req   = edge_rise[BIT_BUZ_CONT] || edge_fall[BIT_BUZ_CONT]
                           || edge_rise[BIT_BUZ_INT] || edge_fall[BIT_BUZ_INT];

    // flash bit moving updates the backlight mode
    assign flash_upd_req = edge_rise[BIT_BL_FLASH] || edge_fall[BIT_BL_FLASH];

    ////////////////////////////////////////////////////////////////////////
    // timers
    ////////////////////////////////////////////////////////////////////////

    // both counters compare at the idle width
    // phase counter is zero-extended for that
    assign half_done = reached(IDLE_W'(s_reg.half_cnt), IDLE_W'(HALF_LIM));
    assign idle_done = reached(s_reg.idle_cnt, IDLE_LIM);

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        s_next     = s_reg;
        s_next.chg = '0;

        // half-second phase for intermittent tone and flashing
        if (half_done) begin
            s_next.half_cnt = '0;
            s_next.phase    = ~s_reg.phase;
        end else begin
            s_next.half_cnt = s_reg.half_cnt + CNT_ONE;
        end

        // inactivity timer: a touch or a host fetch restarts it; buzzer-stop and the switches do not
        if (i_touch || i_fetch) begin
            s_next.idle_cnt = '0;
            s_next.idle_off = 1'b0;
        end else if (i_idle_en && !s_reg.idle_off) begin
            if (idle_done) begin
                s_next.idle_off = 1'b1;
            end else begin
                s_next.idle_cnt = s_reg.idle_cnt + IDLE_ONE;
            end
        end

        // attributes of a newly shown screen
        if (i_scr_shown) begin
            s_next.buz      = i_scr_buz_attr;
            s_next.bl_flash = i_scr_bl_flash;
        end

        // screen darkened by its own timeout
        if (i_timeout_blank) begin
            s_next.scr_off = 1'b1;
        end

        // a later registration elsewhere on the link takes priority away
        if (i_other_prio_reg) begin
            s_next.prio = 1'b0;
        end

        // fetched word: act only on changed defined bits
        if (i_fetch) begin
            s_next.chg  = edge_rise | edge_fall;
            s_next.prev = i_word;
        end

        if (disp_off_req) begin
            s_next.scr_off = 1'b1;
        end
        if (disp_on_req) begin
            s_next.scr_off = 1'b0;
        end

        if (prio_set_req) begin
            s_next.prio = 1'b1;
        end
        if (prio_clr_req) begin
            s_next.prio = 1'b0;
        end

        if (buz_upd_req) begin
            s_next.buz = buz_from_bits(i_word[BIT_BUZ_CONT], i_word[BIT_BUZ_INT]);
        end
        if (flash_upd_req) begin
            s_next.bl_flash = i_word[BIT_BL_FLASH];
        end

        // operator overrides
        if (i_touch) begin
            s_next.scr_off = 1'b0;
        end
        if (i_touch_buz_stop) begin
            s_next.buz = BUZ_OFF;
        end

        // display state: wait holds the screen lit until the first fetch,
        // then show and blank follow the blanking flag
        // an illegal code falls back to waiting for a fetch
        unique case (s_reg.st)
            TSCW_ST_WAIT: begin
                if (i_fetch) begin
                    s_next.st = s_next.scr_off ? TSCW_ST_BLANK : TSCW_ST_SHOW;
                end
            end
            TSCW_ST_SHOW: begin
                if (s_next.scr_off) begin
                    s_next.st = TSCW_ST_BLANK;
                end
            end
            TSCW_ST_BLANK: begin
                if (!s_next.scr_off) begin
                    s_next.st = TSCW_ST_SHOW;
                end
            end
            default: begin
                s_next.st = TSCW_ST_WAIT;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    ////////////////////////////////////////////////////////////////////////

    // asynchronous reset loads constants only
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= S_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        // display follows the state machine
        scr_lit     = (s_reg.st != TSCW_ST_BLANK);
        // flashing darkens every other half period
        flash_dark  = s_reg.bl_flash && s_reg.phase;
        // tone kind, gated by the memory switch below
        tone_on     = buz_sounding(s_reg.buz, s_reg.phase);

        o_screen_on = scr_lit;
        o_backlight = scr_lit && !s_reg.idle_off && !flash_dark;
        o_buzzer    = i_buz_msw_en && tone_on;
        o_priority  = s_reg.prio;
        o_change    = s_reg.chg;
    end
endmodule

// ==== verification/terminal_status_control_word_bench.sv ====
// bench for the control word decoder behind a host model
// assumes tscw_top, tscw_host_model and the bound checker
`timescale 1ns/1ps
module terminal_status_control_word_bench;
    import tscw_pkg::*;
    logic i_clk = 0, i_rst = 1, go = 0, fetch, touch = 0, stp = 0, oth = 0, msw = 1, first = 1, sc, bl, bz, pr;
    logic idle = 0, shown = 0, tmo = 0;
    logic [1:0] attr = 2'h0;
    logic [15:0] word = 16'h0000, fw, chg, prev = 16'h0000, rnd = 16'h005B;
    int error_cnt = 0, n_tests = 0, k;
    always #25 i_clk = ~i_clk;
    tscw_host_model i_tscw_host_model (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_word(word), .o_fetch(fetch),
        .o_word(fw));
    tscw_top #(.HALF_CYC(8), .IDLE_CYC(20)) i_tscw_top (.i_clk(i_clk), .i_rst(i_rst), .i_fetch(fetch), .i_word(fw),
        .i_touch(touch), .i_touch_buz_stop(stp), .i_buz_msw_en(msw), .i_idle_en(idle), .i_scr_shown(shown),
        .i_scr_buz_attr(attr), .i_scr_bl_flash(1'b0), .i_timeout_blank(tmo), .i_other_prio_reg(oth),
        .o_screen_on(sc), .o_backlight(bl), .o_buzzer(bz), .o_priority(pr), .o_change(chg));
    function automatic logic [15:0] xs(input logic [15:0] s);
        s ^= s << 7;
        s ^= s >> 9;
        return s ^ (s << 8);
    endfunction
    function automatic logic [15:0] exp_chg(input logic [15:0] p, v, input logic f);
        return f ? DEFINED_MASK : (p ^ v) & DEFINED_MASK;
    endfunction
    task chk(input logic ok);
        n_tests++;
        if (!ok) begin
            error_cnt++;
            $display("MISMATCH %0t unexpected output", $time);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task put(input logic [15:0] v);
        word = v;
        go = 1;
        tick(1);
        go = 0;
        tick(1);
        chk(chg === exp_chg(prev, v, first));
        prev = v;
        first = 0;
        $display("fetch %h done", v);
    endtask
    task count(input int n, input logic buz);
        k = 0;
        repeat (n) begin
            tick(1);
            k += buz ? int'(bz) : int'(bl);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        tick(20);
        i_rst = 0;
        tick(1);
        put(16'h8000);
        put(16'h0000);
        chk(sc === 1'b0 && bl === 1'b0);
        touch = 1;
        tick(1);
        touch = 0;
        chk(sc === 1'b1);
        put(16'hA000);
        tick(1);
        chk(bz === 1'b1);
        msw = 0;
        tick(2);
        chk(bz === 1'b0);
        msw = 1;
        put(16'hB000);
        count(8, 1);
        chk(k == 8);
        stp = 1;
        tick(1);
        stp = 0;
        chk(bz === 1'b0);
        put(16'h8000);
        put(16'h9000);
        count(32, 1);
        chk(k == 16);
        put(16'hC000);
        chk(pr === 1'b1);
        put(16'h8000);
        chk(pr === 1'b0);
        put(16'hC000);
        oth = 1;
        tick(1);
        oth = 0;
        chk(pr === 1'b0);
        tmo = 1;
        tick(1);
        tmo = 0;
        chk(sc === 1'b0);
        put(16'h4000);
        put(16'hC000);
        chk(sc === 1'b1);
        idle = 1;
        tick(25);
        chk(bl === 1'b0);
        touch = 1;
        tick(1);
        touch = 0;
        idle = 0;
        chk(bl === 1'b1);
        attr = BUZ_INT;
        shown = 1;
        tick(1);
        shown = 0;
        count(16, 1);
        chk(k == 8);
        stp = 1;
        tick(1);
        stp = 0;
        chk(bz === 1'b0);
        put(16'h0100);
        count(16, 0);
        chk(k == 0);
        repeat (16) begin
            rnd = xs(rnd);
            put(rnd);
        end
        print_verdict();
    end
endmodule

// ==== verification/tscw_assertions.sv ====
// checker for tscw_top, bound at the foot
// assumes the top module port names
`timescale 1ns/1ps
module tscw_assertions import tscw_pkg::*; #(parameter int HALF_CYC = 8, parameter longint IDLE_CYC = 20) (
    input wire logic              i_clk, i_rst, i_fetch, i_touch, i_touch_buz_stop, i_buz_msw_en,
    input wire logic              i_scr_shown, i_other_prio_reg, o_screen_on, o_backlight, o_buzzer, o_priority,
    input wire logic [WORD_W-1:0] i_word, o_change
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence cont_req; i_fetch && i_word[BIT_BUZ_CONT] && i_buz_msw_en && !i_touch_buz_stop; endsequence
    sequence cont_act; o_change[BIT_BUZ_CONT] && i_buz_msw_en && !i_touch_buz_stop && !i_scr_shown; endsequence
    change_mask_a: assert property ((o_change & ~DEFINED_MASK) == 16'h0000)
        else $error("undefined bit flagged");
    change_fetch_a: assert property (o_change != 16'h0000 |-> $past(i_fetch))
        else $error("change without fetch");
    disp_clear_a: assert property (i_fetch && !i_word[BIT_DISP] && !i_touch |=>
        !o_change[BIT_DISP] || !o_screen_on) else $error("screen not blanked");
    dark_light_a: assert property (!o_screen_on |-> !o_backlight) else $error("backlight on blank");
    touch_show_a: assert property (i_touch |=> o_screen_on) else $error("touch did not restore");
    prio_other_a: assert property (i_other_prio_reg && !i_fetch |=> !o_priority)
        else $error("priority kept");
    buz_stop_a: assert property (i_touch_buz_stop && !i_scr_shown |=> !o_buzzer) else $error("buzzer not stopped");
    cont_buz_a: assert property (cont_req ##1 cont_act |-> o_buzzer) else $error("buzzer silent");
endmodule
bind tscw_top tscw_assertions #(.HALF_CYC(HALF_CYC), .IDLE_CYC(IDLE_CYC)) i_tscw_assertions (.*);

// ==== verification/tscw_host_model.sv ====
// host controller model: hands the decoder one word fetch per request
// assumes i_go is a one-cycle request from the bench
`timescale 1ns/1ps
module tscw_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_go,
    input  wire logic [15:0] i_word,
    output logic             o_fetch,
    output logic [15:0]      o_word
);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_fetch <= 1'b0;
            o_word  <= 16'h0000;
        end else begin
            o_fetch <= i_go;
            // word is not held outside a fetch
            o_word  <= i_go ? i_word : ~o_word;
        end
    end
endmodule
